// ### shared/scx_params.svh
// Offsets, field positions, passwords and reset values of the calibration transfer block.
`ifndef SCX_PARAMS_SVH
`define SCX_PARAMS_SVH

// ***********************************************
// Word counts and word positions
// ***********************************************
`define SCX_OUT_WORDS 27
`define SCX_IN_WORDS 24
`define SCX_OUT_CMD 0
`define SCX_OUT_DATA 16
`define SCX_OUT_PW 26
`define SCX_IN_STATUS 4
`define SCX_IN_DATA 14

// ***********************************************
// Bit positions
// ***********************************************
`define SCX_CMD_BIT 15
`define SCX_HS_BIT 8
`define SCX_CONF_BIT 9

// ***********************************************
// Passwords
// ***********************************************
`define SCX_PW_WR_SET1 16'h08BE
`define SCX_PW_RD_SET2 16'h08C2
`define SCX_PW_WR_SET2 16'h08C3

// ***********************************************
// Parameter store layout
// ***********************************************
`define SCX_SLOTS 15
`define SCX_SET1_WORDS 10
`define SCX_SET2_WORDS 8
`define SCX_SLOT_MOTION 4'h6
`define SCX_SLOT_FILTER 4'h7
`define SCX_SLOT_AZR 4'h8
`define SCX_SLOT_MOT_CNT 4'hA
`define SCX_SLOT_ZK_POS 4'hB
`define SCX_SLOT_ZK_NEG 4'hC
`define SCX_SLOT_PU_ZERO 4'hD
`define SCX_SLOT_OVL_BLANK 4'hE
`define SCX_SLOT_FORMAT 1
`define SCX_RST_WORD 16'h0000
`define SCX_RST_FORMAT 16'h0001

`endif

// ### shared/scx_pkg.sv
// Types and helper functions of the calibration transfer block.
package scx_pkg;
`include "scx_params.svh"

    typedef logic [15:0] scx_word_t;

    typedef enum logic [1:0] {
        SCX_IDLE = 2'b00,
        SCX_EXEC = 2'b01,
        SCX_COMMIT = 2'b10,
        SCX_HOLD = 2'b11
    } scx_state_t;

    typedef struct packed {
        scx_state_t st;
        logic wr1;
        logic wr2;
        logic cold;
        logic cold1;
        logic cold2;
        logic cold3;
        logic jp1;
        logic jp2;
        logic [`SCX_OUT_WORDS-1:0][15:0] req1;
        logic [`SCX_OUT_WORDS-1:0][15:0] req2;
        logic [`SCX_IN_WORDS-1:0][15:0] rsp;
    } scx_top_st_t;

    typedef struct packed {
        logic [`SCX_SLOTS-1:0][15:0] saved;
        logic [`SCX_SLOTS-1:0][15:0] active;
    } scx_store_st_t;

    // Slot of the store that the i-th word of the second set maps to.
    function automatic logic [3:0] scx_set2_slot(input int i);
        logic [3:0] s;
        s = `SCX_SLOT_MOTION;
        case (i)
            0: s = `SCX_SLOT_MOTION;
            1: s = `SCX_SLOT_MOT_CNT;
            2: s = `SCX_SLOT_FILTER;
            3: s = `SCX_SLOT_AZR;
            4: s = `SCX_SLOT_ZK_POS;
            5: s = `SCX_SLOT_ZK_NEG;
            6: s = `SCX_SLOT_PU_ZERO;
            default: s = `SCX_SLOT_OVL_BLANK;
        endcase
        return s;
    endfunction : scx_set2_slot

    function automatic scx_store_st_t scx_store_reset();
        scx_store_st_t r;
        for (int i = 0; i < `SCX_SLOTS; i++) begin
            r.saved[i] = `SCX_RST_WORD;
            r.active[i] = `SCX_RST_WORD;
        end
        r.saved[`SCX_SLOT_FORMAT] = `SCX_RST_FORMAT;
        r.active[`SCX_SLOT_FORMAT] = `SCX_RST_FORMAT;
        return r;
    endfunction : scx_store_reset
endpackage : scx_pkg

// ### shared/scx_if.sv
// Carrier between the command handler and the parameter store.
`timescale 1ns/100ps
`include "scx_params.svh"
interface scx_if;
    logic wr_set1;
    logic wr_set2;
    logic cold_load;
    logic [`SCX_SET1_WORDS-1:0][15:0] wdata;
    logic [`SCX_SLOTS-1:0][15:0] active;

    modport ctrl (output wr_set1, output wr_set2, output cold_load, output wdata, input active);
    modport store (input wr_set1, input wr_set2, input cold_load, input wdata, output active);
endinterface : scx_if

// ### logic/scx_store.sv
// Parameter store: saved calibration words and the set in effect since the last cold start.
`timescale 1ns/100ps
`include "scx_params.svh"
module scx_store (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Command handler side
    scx_if.store port_if
);
    import scx_pkg::*;

    scx_store_st_t q;
    scx_store_st_t d;

    // *******************************************
    // Next state
    // *******************************************
    always_comb begin
        d = q;
        if (port_if.wr_set1) begin
            for (int i = 0; i < `SCX_SET1_WORDS; i++) begin
                d.saved[i] = port_if.wdata[i];
            end
        end
        if (port_if.wr_set2) begin
            // Shared slots make the second set overwrite the same motion, filter and zero words.
            for (int i = 0; i < `SCX_SET2_WORDS; i++) begin
                d.saved[scx_set2_slot(i)] = port_if.wdata[i];
            end
        end
        // Saved words reach the working set only at a cold start.
        if (port_if.cold_load) begin
            d.active = q.saved;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= scx_store_reset();
        end else begin
            q <= d;
        end
    end

    assign port_if.active = q.active;
endmodule : scx_store

// ### logic/scx_top.sv
// Calibration data transfer command handler on the cyclic process-data words.
`timescale 1ns/100ps
`include "scx_params.svh"
module scx_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Process data written by the host
    input wire logic [`SCX_OUT_WORDS-1:0][15:0] host_output_word_in,
    // Protect jumper, high in the secured position
    input wire logic write_protect_jumper_in,
    // Power-cycle indication, a rising edge loads the saved set
    input wire logic cold_start_in,
    // Process data read by the host
    output logic [`SCX_IN_WORDS-1:0][15:0] host_input_word_out
);
    import scx_pkg::*;

    scx_top_st_t q;
    scx_top_st_t d;
    scx_if store_if ();

    logic cmd;
    logic unlocked;
    scx_word_t pw;

    // *******************************************
    // Parameter store
    // *******************************************
    scx_store u_store (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .port_if(store_if)
    );

    // The words are held stable by the host for the whole command, so their sync is safe.
    always_comb begin
        for (int i = 0; i < `SCX_SET1_WORDS; i++) begin
            store_if.wdata[i] = q.req2[`SCX_OUT_DATA + i];
        end
    end
    assign store_if.wr_set1 = q.wr1;
    assign store_if.wr_set2 = q.wr2;
    assign store_if.cold_load = q.cold;

    assign cmd = q.req2[`SCX_OUT_CMD][`SCX_CMD_BIT];
    assign pw = q.req2[`SCX_OUT_PW];
    assign unlocked = ~q.jp2;

    // *******************************************
    // Next state
    // *******************************************
    always_comb begin
        d = q;
        d.req1 = host_output_word_in;
        d.req2 = q.req1;
        d.jp1 = write_protect_jumper_in;
        d.jp2 = q.jp1;
        d.cold1 = cold_start_in;
        d.cold2 = q.cold1;
        d.cold3 = q.cold2;
        d.cold = q.cold2 & ~q.cold3;
        d.wr1 = 1'b0;
        d.wr2 = 1'b0;
        unique case (q.st)
            SCX_IDLE: begin
                if (cmd) begin
                    d.rsp[`SCX_IN_STATUS][`SCX_HS_BIT] = 1'b1;
                    d.rsp[`SCX_IN_STATUS][`SCX_CONF_BIT] = 1'b0;
                    d.st = SCX_EXEC;
                end
            end
            SCX_EXEC: begin
                d.st = SCX_COMMIT;
                if (pw == `SCX_PW_WR_SET1) begin
                    d.wr1 = unlocked;
                end else if (pw == `SCX_PW_WR_SET2) begin
                    d.wr2 = unlocked;
                end else if (pw == `SCX_PW_RD_SET2) begin
                    for (int i = 0; i < `SCX_SET2_WORDS; i++) begin
                        d.rsp[`SCX_IN_DATA + i] = store_if.active[scx_set2_slot(i)];
                    end
                    d.rsp[`SCX_IN_DATA + `SCX_SET2_WORDS] = `SCX_RST_WORD;
                    d.rsp[`SCX_IN_DATA + `SCX_SET2_WORDS + 1] = `SCX_RST_WORD;
                end else begin
                    for (int i = 0; i < `SCX_SET1_WORDS; i++) begin
                        d.rsp[`SCX_IN_DATA + i] = store_if.active[i];
                    end
                end
            end
            SCX_COMMIT: begin
                // The store takes the words on this edge, so the confirmation follows the write.
                d.rsp[`SCX_IN_STATUS][`SCX_CONF_BIT] = q.wr1 | q.wr2;
                d.st = SCX_HOLD;
            end
            SCX_HOLD: begin
                if (!cmd) begin
                    d.rsp[`SCX_IN_STATUS][`SCX_HS_BIT] = 1'b0;
                    d.rsp[`SCX_IN_STATUS][`SCX_CONF_BIT] = 1'b0;
                    d.st = SCX_IDLE;
                end
            end
        endcase
    end

    // *******************************************
    // State register
    // *******************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign host_input_word_out = q.rsp;
endmodule : scx_top

// ### dv/scx_top_assertions.sv
// Checker of the transfer handshake and read-back words.
`timescale 1ns/100ps
`include "scx_params.svh"
module scx_top_assertions (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Watched ports
    input wire logic [`SCX_OUT_WORDS-1:0][15:0] host_output_word_in,
    input wire logic write_protect_jumper_in,
    input wire logic [`SCX_IN_WORDS-1:0][15:0] host_input_word_out
);
    wire logic cmd = host_output_word_in[0][15];
    wire logic [15:0] pw = host_output_word_in[26];
    wire logic hs = host_input_word_out[4][8];
    wire logic cf = host_input_word_out[4][9];
    wire logic jp = write_protect_jumper_in;
    wire logic wrp = pw == `SCX_PW_WR_SET1 || pw == `SCX_PW_WR_SET2;
    wire logic rd2 = pw == `SCX_PW_RD_SET2;
    wire logic [9:0][15:0] rdw = host_input_word_out[23:14];
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // ****************
    // Properties
    // ****************
    AST_HS_RISE: assert property ($rose(cmd) |-> ##3 $rose(hs))
        else $error("handshake late");
    AST_HS_HOLD: assert property (hs && cmd |=> hs)
        else $error("handshake lost");
    AST_CONF_AFTER_HS: assert property ($rose(cf) |-> $past(hs, 2))
        else $error("confirm before handshake");
    // The handler acts on the words and jumper as sampled two edges before the handshake rises.
    // The host may change them once the handshake is up, so the live values are not used.
    AST_READ_NO_CONF: assert property ($rose(hs) && !$past(wrp, 2) |=> !cf [*3])
        else $error("confirm on read");
    AST_PROTECT: assert property ($rose(hs) && $past(jp, 2) |-> !cf [*4])
        else $error("confirm while secured");
    AST_WRITE_CONF: assert property ($rose(hs) && $past(wrp, 2) && !$past(jp, 2) |-> ##2 cf)
        else $error("write not confirmed");
    AST_RELEASE: assert property (!cmd [*4] |-> !hs && !cf)
        else $error("status not cleared");
    AST_DATA_ON_READ: assert property (!$stable(rdw) |-> $past(hs) && !$past(hs, 2))
        else $error("data words changed outside a read");
    AST_SET2_TAIL: assert property ($rose(hs) && $past(rd2, 2) |=> rdw[9:8] == '0)
        else $error("set two tail words not zero");
    COV_WRITE: cover property ($rose(hs) && $past(wrp, 2) && !$past(jp, 2));
    COV_SET2: cover property ($rose(hs) && $past(rd2, 2));
    COV_PROT: cover property ($rose(hs) && $past(jp, 2));
endmodule : scx_top_assertions
bind scx_top scx_top_assertions i_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .host_output_word_in(host_output_word_in),
    .write_protect_jumper_in(write_protect_jumper_in),
    .host_input_word_out(host_input_word_out));

// ### dv/scx_host_model.sv
// Host controller model that runs transfers on the process-data words.
`timescale 1ns/100ps
`include "scx_params.svh"
module scx_host_model (
    // Clock
    input wire logic clk_in,
    // Process data
    input wire logic [`SCX_IN_WORDS-1:0][15:0] status_words_in,
    output logic [`SCX_OUT_WORDS-1:0][15:0] command_words_out
);
    // ****************
    // Transfer
    // ****************
    initial command_words_out = '0;
    // Holds the command lag cycles past the handshake; cf collects the confirmation, hs the handshake.
    task automatic xfer(input logic [15:0] pw, input logic [9:0][15:0] d,
                        input int lag, output logic cf, output logic hs);
        int n;
        n = 0;
        cf = 1'b0;
        @(negedge clk_in);
        command_words_out[25:16] = d;
        command_words_out[26] = pw;
        command_words_out[0][15] = 1'b1;
        while (status_words_in[4][8] !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        hs = status_words_in[4][8];
        for (int i = 0; i < lag + 6; i++) begin
            if (i == lag) begin
                command_words_out[0][15] = 1'b0;
                // Once the command is down the words are free; disturbing them shows they are ignored.
                command_words_out[26:16] = ~command_words_out[26:16];
            end
            cf = cf | status_words_in[4][9];
            @(negedge clk_in);
        end
    endtask : xfer
endmodule : scx_host_model

// ### dv/scx_top_test.sv
// Self-checking bench of the calibration transfer handler.
`timescale 1ns/100ps
`include "scx_params.svh"
module scx_top_test;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic jp = 1'b0;
    logic cold = 1'b0;
    logic [`SCX_OUT_WORDS-1:0][15:0] out_words;
    logic [`SCX_IN_WORDS-1:0][15:0] in_words;
    int err_total = 0;
    int tests_run = 0;
    logic [9:0][15:0] dflt = {128'h0, 16'h0001, 16'h0000};
    logic [9:0][15:0] d1 = {16'h0032, 16'h0001, 16'h0014, 16'h0002, 16'h0CD1,
        16'h0003, 16'h8001, 16'h0007, 16'h1205, 16'h0BB8};
    logic [9:0][15:0] d2 = {32'h0, 16'h000D, 16'h000C, 16'h000B, 16'h000A,
        16'h0003, 16'h0010, 16'h0005, 16'h0004};
    always #5 clk_in = ~clk_in;
    scx_host_model i_host (.clk_in(clk_in), .status_words_in(in_words),
        .command_words_out(out_words));
    scx_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_output_word_in(out_words),
        .write_protect_jumper_in(jp), .cold_start_in(cold), .host_input_word_out(in_words));
    // ****************
    // Helpers
    // ****************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [15:0] pw, input logic [9:0][15:0] e);
        logic cf;
        logic hs;
        i_host.xfer(pw, '0, 0, cf, hs);
        check("handshake", {15'h0, hs}, 16'h0001);
        check("confirm", {15'h0, cf}, 16'h0000);
        check("status", in_words[4], 16'h0000);
        for (int i = 0; i < 10; i++) begin
            check($sformatf("word %0d", 14 + i), in_words[14 + i], e[i]);
        end
    endtask : rd
    task automatic wr(input logic [15:0] pw, input logic [9:0][15:0] d, input logic c);
        logic cf;
        logic hs;
        i_host.xfer(pw, d, 3, cf, hs);
        check("handshake", {15'h0, hs}, 16'h0001);
        check("confirm", {15'h0, cf}, {15'h0, c});
        check("status", in_words[4], 16'h0000);
    endtask : wr
    task automatic boot;
        cold = 1'b1;
        repeat (6) @(negedge clk_in);
        cold = 1'b0;
        @(negedge clk_in);
    endtask : boot
    // ****************
    // Scenarios
    // ****************
    task automatic t_plain_read;
        rd(16'h0000, dflt);
        rd(16'h1234, dflt);
    endtask : t_plain_read
    task automatic t_set1_download;
        wr(`SCX_PW_WR_SET1, d1, 1'b1);
        rd(16'h0000, dflt);
        boot();
        rd(16'h0000, d1);
    endtask : t_set1_download
    task automatic t_protected;
        logic [9:0][15:0] e;
        e = '0;
        e[0] = d1[6];
        e[2] = d1[7];
        e[3] = d1[8];
        jp = 1'b1;
        wr(`SCX_PW_WR_SET2, d2, 1'b0);
        wr(`SCX_PW_WR_SET1, d2, 1'b0);
        jp = 1'b0;
        boot();
        rd(`SCX_PW_RD_SET2, e);
    endtask : t_protected
    task automatic t_set2_download;
        logic [9:0][15:0] e;
        e = d1;
        e[6] = d2[0];
        e[7] = d2[2];
        e[8] = d2[3];
        wr(`SCX_PW_WR_SET2, d2, 1'b1);
        boot();
        rd(`SCX_PW_RD_SET2, d2);
        rd(16'h0000, e);
    endtask : t_set2_download
    // Reset in mid-run brings back the default parameter sets and a clear status word.
    task automatic t_reset;
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        check("status", in_words[4], 16'h0000);
        check("word 20", in_words[20], 16'h0000);
        rd(16'h0000, dflt);
    endtask : t_reset
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial begin
        #30000;
        err_total++;
        test_done();
    end
    initial begin
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_plain_read();
        t_set1_download();
        t_protected();
        t_set2_download();
        t_reset();
        test_done();
    end
endmodule : scx_top_test
